//--- logic/cbk_key_builder.sv
`timescale 1ns/1ps
// Search key builder for the classification rule engine
module cbk_key_builder
  import cbk_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Parser side
  input wire logic parse_valid,
  input cbk_parse_t parse,
  input wire logic [15:0] port_default_outer,
  input wire logic [15:0] port_default_inner,
  // Lookup side
  output logic key_valid,
  output logic [NUM_SLICES-1:0][KEY_W-1:0] slice_key,
  output logic [NUM_SLICES-1:0][1:0] slice_rank,
  output logic chain_active,
  output logic [2:0] chain_extra_valid,
  output logic [2:0][15:0] chain_extra
);

  //////////////////////////////////////////////////////////////////////////////
  // State
  // All state, registered as one word
  typedef struct packed {
    logic [NUM_CFG-1:0][7:0] cfg;            // Field configurations
    logic chain_en;                          // Slice 0 chained with slice 3
    logic [15:0] key_count;                  // Keys issued, wraps
    logic [1:0] last_cat;                    // Category of last packet
    logic key_valid;
    logic [NUM_SLICES-1:0][KEY_W-1:0] key;
    logic [NUM_SLICES-1:0][1:0] rank;
    logic chain_active;
    logic [2:0] extra_valid;
    logic [2:0][15:0] extra;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cbk_state_t;

  cbk_state_t s_q;
  cbk_state_t s_d;

  //////////////////////////////////////////////////////////////////////////////
  // Offset bases
  logic [POS_W-1:0] tag_bytes;   // Four bytes per VLAN tag
  logic [POS_W-1:0] l2_end;      // Past the link header
  logic [POS_W-1:0] l3_end;      // Past the network header

  // Resolve the link and network header ends
  always_comb begin
    // Tags sit ahead of the type field
    tag_bytes = {8'h00, parse.tag_count, 2'b00};
    unique case (parse.l2_kind)
      CBK_L2_ETH2: l2_end = L2_LEN_ETH2 + tag_bytes;
      CBK_L2_SNAP_PUB: l2_end = L2_LEN_SNAP_PUB + tag_bytes;
      CBK_L2_LLC: l2_end = L2_LEN_LLC + tag_bytes;
      CBK_L2_SNAP_PRIV: l2_end = L2_LEN_LLC + tag_bytes;
      CBK_L2_PPPOE: l2_end = L2_LEN_PPPOE + tag_bytes;
      default: l2_end = L2_LEN_ETH2 + tag_bytes;               // Illegal kind
    endcase
    // Non-IP frames keep the link end so a base of 011 still lands sensibly
    l3_end = l2_end;
    if (parse.category == CBK_CAT_IPV4) begin
      l3_end = l2_end + {6'h00, parse.ihl, 2'b00};
      if (parse.ah_present) begin
        // AH length is in words, less two
        l3_end = l3_end + {1'b0, 9'({1'b0, parse.ah_len} + 9'h002), 2'b00};
      end
    end else if (parse.category == CBK_CAT_IPV6) begin
      // Parser sums the extension bytes
      l3_end = l2_end + IPV6_BASE_LEN + parse.ext_bytes;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field extraction: slices 0..2 per category, slice 3 from the chain set
  logic [NUM_SLICES-1:0][FIELDS_PER_SET-1:0][7:0] sel_cfg;
  cbk_field_t [NUM_SLICES-1:0][FIELDS_PER_SET-1:0] fld;
  cbk_field_t [2:0] extra_fld;
  logic [1:0] cat_idx; // Set number, never past the last
  logic [6:0] set_base; // First word of the set

  // Pick the configuration set of slices 0..2 by packet category
  always_comb begin
    // Illegal codes fall back to the non-IP set
    unique case (parse.category)
      CBK_CAT_IPV4: cat_idx = 2'h0;
      CBK_CAT_IPV6: cat_idx = 2'h1;
      default: cat_idx = 2'h2;
    endcase
    // Three slices of nine words each
    set_base = 7'(27 * int'(cat_idx));
    for (int sl = 0; sl < NUM_SLICES; sl++) begin
      for (int f = 0; f < FIELDS_PER_SET; f++) begin
        if (sl == 3) begin
          sel_cfg[sl][f] = s_q.cfg[CHAIN_CFG_BASE + f];
        end else begin
          sel_cfg[sl][f] = s_q.cfg[int'(set_base) + 9 * sl + f];
        end
      end
    end
  end

  // 39 in parallel: area for latency
  // One extractor per key field
  for (genvar gs = 0; gs < NUM_SLICES; gs++) begin : g_slice
    for (genvar gf = 0; gf < FIELDS_PER_SET; gf++) begin : g_field
      cbk_field_extract u_fx (
        .cfg(sel_cfg[gs][gf]),
        .l2_end(l2_end),
        .l3_end(l3_end),
        .bytes(parse.bytes),
        .frame_len(parse.frame_len),
        .field(fld[gs][gf])
      );
    end
  end

  // Remaining three chain fields travel beside the slice 3 key
  // Used only while chaining is on
  for (genvar ge = 0; ge < 3; ge++) begin : g_extra
    cbk_field_extract u_fx (
      .cfg(s_q.cfg[CHAIN_CFG_BASE + FIELDS_PER_SET + ge]),
      .l2_end(l2_end),
      .l3_end(l3_end),
      .bytes(parse.bytes),
      .frame_len(parse.frame_len),
      .field(extra_fld[ge])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Common key content
  logic [1:0] otag_st;
  logic [1:0] itag_st;
  logic [15:0] otag;
  logic [15:0] itag;
  logic [1:0] ttl_cls;
  logic [1:0] link_fr;
  logic [1:0] net_fr;
  logic [7:0] port_map;

  // Tags, time-to-live class and framing codes
  always_comb begin
    // VID is the low twelve bits
    if (!parse.outer_present) begin
      otag_st = TAG_NONE;
    end else if (parse.outer_tag[11:0] == 12'h000) begin
      otag_st = TAG_VID_ZERO;
    end else begin
      otag_st = TAG_VID_SET;
    end
    if (!parse.inner_present) begin
      itag_st = TAG_NONE;
    end else if (parse.inner_tag[11:0] == 12'h000) begin
      itag_st = TAG_VID_ZERO;
    end else begin
      itag_st = TAG_VID_SET;
    end

    // Absent tags use port defaults
    otag = parse.outer_present ? parse.outer_tag : port_default_outer;
    itag = parse.inner_present ? parse.inner_tag : port_default_inner;

    // Time-to-live class
    if (parse.ttl == 8'h00) begin
      ttl_cls = TTL_ZERO;
    end else if (parse.ttl == 8'h01) begin
      ttl_cls = TTL_ONE;
    end else if (parse.ttl == 8'hff) begin
      ttl_cls = TTL_MAX;
    end else begin
      ttl_cls = TTL_OTHER;
    end

    // Others share one code
    unique case (parse.l2_kind)
      CBK_L2_ETH2: link_fr = LINK_FR_ETH2;
      CBK_L2_SNAP_PUB: link_fr = LINK_FR_SNAP_PUB;
      default: link_fr = LINK_FR_OTHER;
    endcase
    unique case (parse.category)
      CBK_CAT_IPV4: net_fr = NET_FR_IPV4;
      CBK_CAT_IPV6: net_fr = NET_FR_IPV6;
      default: net_fr = NET_FR_NONIP;
    endcase
    // Key carries the ingress port as one hot; the rule's mask decides
    port_map = 8'h01 << parse.ingress_port;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assemble one slice key
  function automatic logic [KEY_W-1:0] build_key(
    input logic [1:0] slice_no,
    input cbk_field_t [FIELDS_PER_SET-1:0] f
  );
    logic [KEY_W-1:0] k;
    // Reserved bits stay zero
    k = '0;
    k[K_PORT_LSB +: 8] = port_map;
    k[K_OTAG_ST_LSB +: 2] = otag_st;
    k[K_ITAG_ST_LSB +: 2] = itag_st;
    k[K_LINK_FR_LSB +: 2] = link_fr;
    k[K_NET_FR_LSB +: 2] = net_fr;
    k[K_SVC_LSB +: 8] = parse.svc_byte;
    k[K_PROTO_LSB +: 8] = parse.proto_byte;
    k[K_FRAG] = parse.fragmented;
    k[K_NONFIRST] = parse.non_first;
    k[K_AUTH] = parse.ah_present;
    k[K_TTL_LSB +: 2] = ttl_cls;
    k[K_SESSION] = parse.session;
    k[K_OTAG_LSB +: 16] = otag;
    k[K_ITAG_LSB +: 16] = itag;
    for (int i = 0; i < FIELDS_PER_SET; i++) begin
      // Flag 8 sits above the rest
      if (i == 8) begin
        k[K_VALID8] = f[i].valid;
      end else begin
        k[K_VALID_LSB + i] = f[i].valid;
      end
      k[K_FIELD_LSB + 16 * i +: 16] = f[i].data;
    end
    k[K_SLICE_LSB +: 2] = slice_no;
    k[1:0] = SLICE_VALID_MARK;
    return k;
  endfunction : build_key

  //////////////////////////////////////////////////////////////////////////////
  // APB decode helpers
  logic apb_access;       // Access phase, not yet answered
  logic [11:0] cfg_off;   // Offset into the field configuration area
  logic cfg_hit;          // Address falls on a configuration word
  logic [6:0] cfg_idx;    // Configuration word index

  // Misaligned or unmapped: error
  always_comb begin
    apb_access = psel && penable && !s_q.pready;
    cfg_off = paddr - ADDR_CFG_BASE;
    cfg_idx = cfg_off[8:2];
    cfg_hit = (paddr >= ADDR_CFG_BASE) && (cfg_off[1:0] == 2'b00)
              && (cfg_off[11:2] < 10'(NUM_CFG));
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.key_valid = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    // Register access, answered one cycle into the access phase
    // giving exactly one wait state
    if (apb_access) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      // Chaining enable
      if (paddr == ADDR_CTRL) begin
        if (pwrite) begin
          s_d.chain_en = pwdata[CTRL_CHAIN_BIT];
        end else begin
          s_d.prdata[CTRL_CHAIN_BIT] = s_q.chain_en;
        end
      end else if (paddr == ADDR_STATUS) begin
        // Read only; writes dropped
        if (!pwrite) begin
          s_d.prdata = {14'h0000, s_q.last_cat, s_q.key_count};
        end
      end else if (cfg_hit) begin
        // Low byte kept
        if (pwrite) begin
          s_d.cfg[cfg_idx] = pwdata[7:0];
        end else begin
          s_d.prdata = {24'h000000, s_q.cfg[cfg_idx]};
        end
      end else begin
        s_d.pslverr = 1'b1;                                    // Unmapped address
      end
    end

    // Key issue, one cycle after the parse result
    // Same-cycle write: next packet
    if (parse_valid) begin
      s_d.key_valid = 1'b1;
      for (int sl = 0; sl < NUM_SLICES; sl++) begin
        s_d.key[sl] = build_key(2'(sl), fld[sl]);
      end
      s_d.chain_active = s_q.chain_en && (parse.category == CBK_CAT_IPV6);
      for (int e = 0; e < 3; e++) begin
        s_d.extra_valid[e] = extra_fld[e].valid;
        s_d.extra[e] = extra_fld[e].data;
      end
      s_d.key_count = s_q.key_count + 16'h0001;
      s_d.last_cat = parse.category;
    end

    // Priority ranks, 0 lowest; they follow the registered chain bit,
    // so they lag a control write
    if (s_q.chain_en) begin
      // Slice 1 lowest, pair on top
      s_d.rank = RANK_CHAIN;
    end else begin
      // Rank equals slice number
      s_d.rank = RANK_PLAIN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  // Reset clears all, then loads the defaults;
  // only the rank default is non-zero; a key in flight is lost
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.cfg <= {NUM_CFG{CFG_RESET}};
      s_q.chain_en <= CTRL_RESET;
      s_q.rank <= RANK_PLAIN;
    end else begin
      // No enable: s_d holds or rewrites
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  // Keys hold between key_valid pulses
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign key_valid = s_q.key_valid;
  assign slice_key = s_q.key;
  assign slice_rank = s_q.rank;
  assign chain_active = s_q.chain_active;
  assign chain_extra_valid = s_q.extra_valid;
  assign chain_extra = s_q.extra;

endmodule : cbk_key_builder

//--- logic/cbk_pkg.sv
// Operation
// - Packet-start base is first destination MAC byte
// - L2-end base follows framing kind and tags
// - IPv4 L3-end past options, or past AH
// - IPv6 L3-end past base or parsed extensions
// - Field: 3-bit base, 5-bit halfword offset
// - Field starts 2N bytes after base
// - Base codes 000, 010, 011; others reserved
// - Four slice keys; slice 0 chains slice 3
// - Nine fields per category; chain uses twelve
// - Slice priority order depends on chaining
// - Key 232 bits; port map bits 231:224
// - Tag status 00 none, 01 zero, 11 nonzero
// - Link framing 219:218, network framing 217:216
// - Service byte 215:208, protocol byte 207:200
// - Bits 199:197 fragment, non-first, authentication
// - Bits 196:195 classify time-to-live
// - Bit 194 session flag; 193, 7:4 zero
// - Bits 192, 191:184 hold field valid flags
// - Outer tag 183:168, inner 167:152, default fallback
// - Nine fields packed 151:136 down to 23:8
// - Bits 3:2 carry the slice number
// - Bits 1:0 are 11 for valid key
package cbk_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int KEY_W = 232;
  localparam int NUM_SLICES = 4;
  localparam int FIELDS_PER_SET = 9;
  localparam int CHAIN_FIELDS = 12;
  localparam int WIN_BYTES = 128;        // Header window handed over by the parser
  localparam int POS_W = 12;             // Byte position width
  localparam int NUM_CFG = 3 * 3 * FIELDS_PER_SET + CHAIN_FIELDS; // 93 field configs
  localparam int CHAIN_CFG_BASE = 81;

  //////////////////////////////////////////////////////////////////////////////
  // Field configuration layout
  localparam int CFG_OFS_LSB = 0;
  localparam int CFG_OFS_W = 5;
  localparam int CFG_BASE_LSB = 5;
  localparam int CFG_BASE_W = 3;
  localparam logic [2:0] BASE_PACKET_START = 3'h0;
  localparam logic [2:0] BASE_L2_END = 3'h2;
  localparam logic [2:0] BASE_L3_END = 3'h3;

  //////////////////////////////////////////////////////////////////////////////
  // Key field positions
  localparam int K_PORT_LSB = 224;
  localparam int K_OTAG_ST_LSB = 222;
  localparam int K_ITAG_ST_LSB = 220;
  localparam int K_LINK_FR_LSB = 218;
  localparam int K_NET_FR_LSB = 216;
  localparam int K_SVC_LSB = 208;
  localparam int K_PROTO_LSB = 200;
  localparam int K_FRAG = 199;
  localparam int K_NONFIRST = 198;
  localparam int K_AUTH = 197;
  localparam int K_TTL_LSB = 195;
  localparam int K_SESSION = 194;
  localparam int K_VALID8 = 192;
  localparam int K_VALID_LSB = 184;
  localparam int K_OTAG_LSB = 168;
  localparam int K_ITAG_LSB = 152;
  localparam int K_FIELD_LSB = 8;
  localparam int K_SLICE_LSB = 2;
  localparam logic [1:0] SLICE_VALID_MARK = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic [1:0] TAG_NONE = 2'h0;
  localparam logic [1:0] TAG_VID_ZERO = 2'h1;
  localparam logic [1:0] TAG_VID_SET = 2'h3;
  localparam logic [1:0] LINK_FR_ETH2 = 2'h0;
  localparam logic [1:0] LINK_FR_SNAP_PUB = 2'h1;
  localparam logic [1:0] LINK_FR_OTHER = 2'h3;
  localparam logic [1:0] NET_FR_IPV4 = 2'h0;
  localparam logic [1:0] NET_FR_IPV6 = 2'h1;
  localparam logic [1:0] NET_FR_NONIP = 2'h3;
  localparam logic [1:0] TTL_ZERO = 2'h0;
  localparam logic [1:0] TTL_ONE = 2'h1;
  localparam logic [1:0] TTL_OTHER = 2'h2;
  localparam logic [1:0] TTL_MAX = 2'h3;

  // Link header byte counts, excluding VLAN tags
  localparam logic [POS_W-1:0] L2_LEN_ETH2 = 12'h00e;
  localparam logic [POS_W-1:0] L2_LEN_LLC = 12'h010;
  localparam logic [POS_W-1:0] L2_LEN_SNAP_PUB = 12'h016;
  localparam logic [POS_W-1:0] L2_LEN_PPPOE = 12'h016;
  localparam logic [POS_W-1:0] IPV6_BASE_LEN = 12'h028;

  typedef enum logic [1:0] {
    CBK_CAT_IPV4 = 2'h0,
    CBK_CAT_IPV6 = 2'h1,
    CBK_CAT_NONIP = 2'h2
  } cbk_cat_t;

  typedef enum logic [2:0] {
    CBK_L2_ETH2 = 3'h0,
    CBK_L2_SNAP_PUB = 3'h1,
    CBK_L2_LLC = 3'h2,
    CBK_L2_SNAP_PRIV = 3'h3,
    CBK_L2_PPPOE = 3'h4
  } cbk_l2_t;

  //////////////////////////////////////////////////////////////////////////////
  // APB map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CFG_BASE = 12'h100;
  localparam int CTRL_CHAIN_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] RANK_PLAIN = 8'he4;  // Slices 3..0 ranked 3,2,1,0
  localparam logic [7:0] RANK_CHAIN = 8'h92;  // Slices 3..0 ranked 2,1,0,2

  //////////////////////////////////////////////////////////////////////////////
  // Parse result from the header parser
  typedef struct packed {
    logic [WIN_BYTES-1:0][7:0] bytes;  // Byte 0 is first destination MAC byte
    logic [13:0] frame_len;            // Received frame length in bytes
    cbk_cat_t category;
    cbk_l2_t l2_kind;
    logic [1:0] tag_count;             // VLAN tags ahead of the type field
    logic [3:0] ihl;                   // IPv4 header length in words
    logic ah_present;
    logic [7:0] ah_len;                // AH payload length field
    logic [POS_W-1:0] ext_bytes;       // IPv6 extension bytes parsed
    logic [2:0] ingress_port;
    logic outer_present;
    logic [15:0] outer_tag;
    logic inner_present;
    logic [15:0] inner_tag;
    logic [7:0] svc_byte;
    logic [7:0] proto_byte;
    logic fragmented;
    logic non_first;
    logic [7:0] ttl;
    logic session;
  } cbk_parse_t;

  // User field result
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } cbk_field_t;

endpackage : cbk_pkg

//--- logic/cbk_field_extract.sv
`timescale 1ns/1ps
// One user field: resolve base, add halfword offset, fetch two bytes
module cbk_field_extract
  import cbk_pkg::*;
(
  input wire logic [7:0] cfg,
  input wire logic [POS_W-1:0] l2_end,
  input wire logic [POS_W-1:0] l3_end,
  input wire logic [WIN_BYTES-1:0][7:0] bytes,
  input wire logic [13:0] frame_len,
  output cbk_field_t field
);

  logic [2:0] base_sel;      // Selected base code
  logic [4:0] ofs;           // Offset in halfwords
  logic [POS_W-1:0] base;    // Resolved base position
  logic [POS_W-1:0] pos;     // First byte of the field
  logic base_ok;             // Base code is a legal one
  logic [13:0] limit;        // Bytes actually available

  // Decode base and position
  always_comb begin
    base_sel = cfg[CFG_BASE_LSB +: CFG_BASE_W];
    ofs = cfg[CFG_OFS_LSB +: CFG_OFS_W];
    base_ok = 1'b1;
    unique case (base_sel)
      BASE_PACKET_START: base = '0;
      BASE_L2_END: base = l2_end;
      BASE_L3_END: base = l3_end;
      default: begin
        base = '0;                   // Reserved code
        base_ok = 1'b0;
      end
    endcase
    pos = base + {6'h00, ofs, 1'b0};
    limit = (frame_len < 14'(WIN_BYTES)) ? frame_len : 14'(WIN_BYTES);
  end

  // Fetch two bytes; nothing past the frame or window is trusted
  always_comb begin
    field.valid = base_ok && ({2'h0, pos} + 14'h0001 < limit);
    if (field.valid) begin
      field.data = {bytes[pos[6:0]], bytes[7'(pos[6:0] + 7'h01)]};
    end else begin
      field.data = 16'h0000;
    end
  end

endmodule : cbk_field_extract

//--- verif/cbk_key_builder_asserts.sv
`timescale 1ns/1ps
// Checker beside the key builder; sees only its ports
module cbk_key_builder_asserts
  import cbk_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic parse_valid,
  input cbk_parse_t parse,
  input wire logic key_valid,
  input wire logic [NUM_SLICES-1:0][KEY_W-1:0] slice_key,
  input wire logic [NUM_SLICES-1:0][1:0] slice_rank
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Key timing and fixed fields
  AST_KEY_LATENCY: assert property (key_valid == $past(parse_valid))
    else $error("key pulse not one cycle after parse");
  AST_SLICE_MARK: assert property (key_valid |-> slice_key[0][1:0] == 2'h3 &&
    slice_key[1][1:0] == 2'h3 && slice_key[2][1:0] == 2'h3 && slice_key[3][1:0] == 2'h3)
    else $error("slice validity marker wrong");
  AST_SLICE_NUM: assert property (key_valid |-> slice_key[0][3:2] == 2'h0 &&
    slice_key[1][3:2] == 2'h1 && slice_key[2][3:2] == 2'h2 && slice_key[3][3:2] == 2'h3)
    else $error("slice number wrong");
  AST_RSVD_ZERO: assert property (key_valid |-> !slice_key[0][193] &&
    slice_key[0][7:4] == 4'h0) else $error("reserved key bits set");
  AST_TAG_CODE: assert property (key_valid |-> slice_key[0][223:222] != 2'h2 &&
    slice_key[0][221:220] != 2'h2) else $error("reserved tag status code");
  AST_TTL_CLASS: assert property (key_valid |-> slice_key[0][196:195] ==
    ($past(parse.ttl) == 8'h00 ? TTL_ZERO : $past(parse.ttl) == 8'h01 ? TTL_ONE :
    $past(parse.ttl) == 8'hff ? TTL_MAX : TTL_OTHER)) else $error("ttl class wrong");
  AST_SVC_PROTO: assert property (key_valid |-> slice_key[0][215:200] ==
    {$past(parse.svc_byte), $past(parse.proto_byte)}) else $error("service or proto wrong");
  AST_PORT_MAP: assert property (key_valid |->
    slice_key[0][231:224] == (8'h01 << $past(parse.ingress_port))) else $error("port map wrong");
  // Either chaining mode keeps slice 1 below slice 2 below slice 3
  AST_RANK_ORDER: assert property (slice_rank[1] < slice_rank[2] &&
    slice_rank[2] < slice_rank[3]) else $error("slice ranks out of order");
  // At most one wait state on the register bus
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("register bus answer late");

  C_KEY: cover property (key_valid);
  C_CHAIN: cover property (slice_rank[0] == slice_rank[3]);
  C_APB: cover property (psel && penable && pready);
endmodule : cbk_key_builder_asserts

//--- verif/cbk_parser_model.sv
`timescale 1ns/1ps
// Header parser stand-in: one-cycle parse pulse, then stale data scrambled
module cbk_parser_model
  import cbk_pkg::*;
(
  input wire logic clock,
  output logic parse_valid,
  output cbk_parse_t parse,
  output logic [15:0] port_default_outer,
  output logic [15:0] port_default_inner
);
  // Port defaults, used when a tag is missing
  initial begin
    parse_valid = 1'b0;
    parse = '0;
    port_default_outer = 16'h0fed;
    port_default_inner = 16'h0123;
  end

  // Pulse one result; afterwards the bus shows inverted bits, not the old value
  task send(input cbk_parse_t p);
    @(posedge clock);
    parse_valid <= 1'b1;
    parse <= p;
    @(posedge clock);
    parse_valid <= 1'b0;
    parse <= ~p;
  endtask : send
endmodule : cbk_parser_model

//--- verif/cbk_key_builder_bench.sv
`timescale 1ns/1ps
bind cbk_key_builder cbk_key_builder_asserts chk_u (.clock(clock), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pready(pready), .parse_valid(parse_valid), .parse(parse),
  .key_valid(key_valid), .slice_key(slice_key), .slice_rank(slice_rank));

module cbk_key_builder_bench
  import cbk_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, parse_valid, key_valid, chain_active, err;
  logic [15:0] dflt_outer, dflt_inner;
  logic [2:0] ext_v;
  logic [2:0][15:0] ext_d;
  cbk_parse_t parse, p;
  logic [NUM_SLICES-1:0][KEY_W-1:0] slice_key;
  logic [NUM_SLICES-1:0][1:0] slice_rank;
  logic [KEY_W-1:0] k;
  int error_cnt = 0;
  int checked = 0;
  // Field configs: legal bases, reserved base, past frame end, last fitting word
  logic [7:0] cfg [9] = '{8'h03, 8'h40, 8'h60, 8'h20, 8'h1f, 8'h1d, 8'h00, 8'h00, 8'h00};
  logic [15:0] exp_d [9] = '{16'h0607, 16'h0e0f, 16'h2223, 16'h0, 16'h0, 16'h3a3b,
    16'h0001, 16'h0001, 16'h0001};
  logic [8:0] exp_v = 9'h1e7;
  logic [7:0] ttl_v [4] = '{8'h00, 8'h01, 8'hff, 8'h07};
  logic [1:0] ttl_e [4] = '{2'h0, 2'h1, 2'h3, 2'h2};

  cbk_key_builder dut_u (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .parse_valid(parse_valid), .parse(parse),
    .port_default_outer(dflt_outer), .port_default_inner(dflt_inner), .key_valid(key_valid),
    .slice_key(slice_key), .slice_rank(slice_rank), .chain_active(chain_active),
    .chain_extra_valid(ext_v), .chain_extra(ext_d));
  cbk_parser_model prs_u (.clock(clock), .parse_valid(parse_valid), .parse(parse),
    .port_default_outer(dflt_outer), .port_default_inner(dflt_inner));

  ////////////////////////////////////////////////////////////////////////////////
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One transfer; waits for pready without assuming its latency
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock);
    end
    chk(pready, 1, "bus answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Hand a parse result over and grab slice 0 key
  task send_key(input cbk_parse_t x);
    int n;
    n = 0;
    prs_u.send(x);
    #1;
    while (key_valid !== 1'b1 && n < 8) begin
      @(posedge clock);
      #1;
      n++;
    end
    k = slice_key[0];
    chk(key_valid, 1, "key pulse");
  endtask : send_key

  task results();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog, tests
  initial forever #2.5 clock = ~clock;

  // Whole run is under a hundred cycles
  initial begin
    #100000;
    error_cnt++;
    results();
  end

  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b0, ADDR_CFG_BASE + 12'h014, 32'h0);
    chk(rd, {24'h0, CFG_RESET}, "cfg reset");
    apb(1'b1, 12'h800, 32'h1);
    chk(err, 1, "unmapped");
    for (int i = 0; i < 9; i++) apb(1'b1, ADDR_CFG_BASE + 12'(4 * i), {24'h0, cfg[i]});
    apb(1'b0, ADDR_CFG_BASE + 12'h00c, 32'h0);
    chk(rd, 32'h20, "cfg readback");
    // Byte i of the window holds i, so a field reads {pos, pos+1}
    p = '0;
    for (int i = 0; i < WIN_BYTES; i++) p.bytes[i] = 8'(i);
    p.frame_len = 14'd60;
    p.category = CBK_CAT_IPV4;
    p.l2_kind = CBK_L2_ETH2;
    p.ihl = 4'h5;
    p.ingress_port = 3'h3;
    p.outer_present = 1'b1;
    p.outer_tag = 16'ha000;
    {p.svc_byte, p.proto_byte, p.ttl} = 24'hb80640;
    p.fragmented = 1'b1;
    p.session = 1'b1;
    send_key(p);
    for (int i = 0; i < 9; i++) begin
      chk(k[K_FIELD_LSB + 16 * i +: 16], exp_d[i], "field data");
      chk(i < 8 ? k[K_VALID_LSB + i] : k[K_VALID8], exp_v[i], "field valid");
    end
    chk(k[223:216], 8'h40, "tag status and framing");
    chk(k[199:193], 7'h4a, "flags ttl session");
    chk(k[183:152], 32'ha0000123, "tags");
    for (int s = 0; s < 4; s++) chk(slice_key[s][3:0], {s[1:0], 2'h3}, "slice tail");
    chk(slice_rank, 8'he4, "ranks plain");
    // One VLAN tag and an authentication header move both bases
    p.tag_count = 2'h1;
    p.ah_present = 1'b1;
    p.ah_len = 8'h01;
    p.inner_present = 1'b1;
    p.inner_tag = 16'h0777;
    send_key(p);
    chk(k[K_FIELD_LSB + 16 +: 16], 16'h1213, "l2 end");
    chk(k[K_FIELD_LSB + 32 +: 16], 16'h3233, "l3 end");
    chk(k[221:220], 2'h3, "inner status");
    chk(k[197], 1, "auth");
    for (int i = 0; i < 4; i++) begin
      p.ttl = ttl_v[i];
      send_key(p);
      chk(k[196:195], ttl_e[i], "ttl class");
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[15:0], 16'd6, "keys issued");
    apb(1'b1, ADDR_CFG_BASE + 12'(4 * 27), 32'h60);
    apb(1'b1, ADDR_CFG_BASE + 12'(4 * CHAIN_CFG_BASE), 32'h05);
    apb(1'b1, ADDR_CFG_BASE + 12'(4 * (CHAIN_CFG_BASE + 9)), 32'h02);
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (2) @(posedge clock);
    #1;
    chk(slice_rank, 8'h92, "ranks chained");
    p.category = CBK_CAT_IPV6;
    send_key(p);
    chk(chain_active, 1, "chain active");
    chk(k[K_FIELD_LSB +: 16], 16'h3a3b, "ipv6 l3 end");
    chk(slice_key[3][K_FIELD_LSB +: 16], 16'h0a0b, "chain slice field");
    chk({ext_v, ext_d[0]}, {3'h7, 16'h0405}, "chain extra");
    results();
  end
endmodule : cbk_key_builder_bench
